// ---- clock_far_side_model.sv ----
// Model of the oscillators and of the clock consumers
`timescale 1ns/10ps
`default_nettype none
module clock_far_side_model (
   input  wire logic pclk,
   input  wire logic xtal_run,
   input  wire logic measure,
   input  wire logic processor_clock_out,
   output logic      rc_clock,
   output logic      xtal_clock,
   output int        min_high
);
   logic rc_q = 1'b0;
   logic xt_q = 1'b0;
   int   rc_n = 0;
   int   xt_n = 0;
   int   hi_n = 0;
   int   min_q = 99;
   assign rc_clock   = rc_q;
   assign xtal_clock = xt_q;
   assign min_high   = min_q;
   // Internal oscillator, half period of five bus cycles
   always @(posedge pclk) begin
      rc_n <= (rc_n == 4) ? 0 : rc_n + 1;
      if (rc_n == 4) rc_q <= ~rc_q;
   end
   // Crystal runs whatever the main supply does; dies low
   always @(posedge pclk) begin
      xt_n <= (xt_n == 6) ? 0 : xt_n + 1;
      if (!xtal_run) xt_q <= 1'b0;
      else if (xt_n == 6) xt_q <= ~xt_q;
   end
   // Consumer: shortest high phase seen, to catch glitches
   always @(posedge pclk) begin
      hi_n <= (processor_clock_out && measure) ? hi_n + 1 : 0;
      if (!processor_clock_out && hi_n != 0 && hi_n < min_q) min_q <= hi_n;
   end
endmodule
`default_nettype wire

// ---- clock_source_select_32k.sv ----
// Glitch-free 32 kHz source selector with clock output gating and APB
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "clock_source_select_32k_cfg.svh"

// Notes on behaviour
// R1: Without a crystal, outputs and control run from the internal oscillator.
// R2: A running, qualified crystal drives the clock outputs; loss detection still counts RC edges.
// R3: During a switch the output holds a stable phase; no glitches.
// R4: Crystal loss drops the selection back to the internal oscillator.
// R5: Source status reads 0 for internal oscillator, 1 for crystal.
// R6: Each source change sets a sticky flag; interrupt only when unmasked.
// R7: Selected clock drives processor and peripheral outputs, gated by startup.
// R8: Processor output can stay on in low-power off, applied by power state.
// R9: Processor output enable resets to 1, only by backup power-on reset.
// R10: Peripheral output only enabled by power state machine in normal on.
// R11: Peripheral drive: 00 default, 01 strong, 11 weak, 10 high impedance.
// R12: Crystal keeps running from backup cell without main supply.
// R13: Rights protect mode keeps processor output enabled in every state.
// R14: Backup power-on reset returns all contents of this block to their defaults.
// R15: Crystal valid after a run of good edges; change event synchronised.
module clock_source_select_32k (
   input  wire logic                                      pclk,
   input  wire logic                                      presetn,
   input  wire logic                                      psel,
   input  wire logic                                      penable,
   input  wire logic                                      pwrite,
   input  wire logic [11:0]                               paddr,
   input  wire logic [31:0]                               pwdata,
   output logic      [31:0]                               prdata,
   output logic                                           pready,
   output logic                                           pslverr,
   input  wire logic                                      rc_clock,
   input  wire logic                                      xtal_clock,
   input  wire logic                                      main_supply_node,
   input  wire logic                                      startup_done,
   input  wire clock_source_select_32k_pkg::power_state_type power_state,
   output logic                                           processor_clock_out,
   output logic                                           peripheral_clock_out,
   output logic                                           peripheral_clock_oe,
   output logic      [1:0]                                peripheral_clock_drive_sel,
   output logic                                           clock_source_status,
   output logic                                           xtal_osc_enable,
   output logic                                           irq
);

   // ---------------------------------------------------------------
   // Local state
   // ---------------------------------------------------------------
   logic [4:0]  ctrl_q;
   logic        mask_q;
   logic        flag_q;
   logic [2:0]  rc_sync_q;
   logic [2:0]  xt_sync_q;
   logic [7:0]  good_cnt_q;
   logic [7:0]  loss_cnt_q;
   logic        xtal_valid_q;
   logic        sel_xtal_q;
   logic        src_change_q;
   logic        clk_q;
   clock_source_select_32k_pkg::source_state_type src_q;

   logic        rc_rise;
   logic        xt_rise;
   logic        wr_en;
   logic        rd_en;
   logic        mapped;
   logic        proc_en;
   logic        periph_en;

   // Edge test on the synchronised copies only, never the first stage
   function automatic logic rise(input logic [2:0] s);
      rise = s[1] & ~s[2];
   endfunction

   function automatic logic addr_is(input logic [11:0] a,
                                    input logic [11:0] off);
      addr_is = (a == off);
   endfunction

   assign rc_rise = rise(rc_sync_q);
   assign xt_rise = rise(xt_sync_q);

   // ---------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------
   assign mapped = addr_is(paddr, `CSS_OFF_CTRL)   |
                   addr_is(paddr, `CSS_OFF_STATUS) |
                   addr_is(paddr, `CSS_OFF_EVENT)  |
                   addr_is(paddr, `CSS_OFF_MASK);
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign wr_en   = psel & penable & pwrite & mapped;
   assign rd_en   = psel & penable & ~pwrite;

   // Control register; only the backup reset restores defaults
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `CSS_CTRL_RESET; // R9 R14
      end else if (wr_en && addr_is(paddr, `CSS_OFF_CTRL)) begin
         ctrl_q <= pwdata[4:0];
      end
   end

   // Mask register, masked after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= `CSS_MASK_RESET;
      end else if (wr_en && addr_is(paddr, `CSS_OFF_MASK)) begin
         mask_q <= pwdata[`CSS_EV_SRC_CHANGE];
      end
   end

   // Sticky change flag; a read clears it, a new change wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= 1'b0;
      end else if (src_change_q) begin
         flag_q <= 1'b1; // R6
      end else if (rd_en && addr_is(paddr, `CSS_OFF_EVENT) && prdata[0]) begin
         flag_q <= 1'b0;
      end
   end

   assign irq = flag_q & ~mask_q; // R6

   // Read data, registered in the setup cycle so it is ready at access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            `CSS_OFF_CTRL:   prdata <= {27'h0, ctrl_q};
            `CSS_OFF_STATUS: prdata <= {16'h0, `CSS_ID_VALUE, 5'h0,
                                        xtal_valid_q, sel_xtal_q,
                                        sel_xtal_q};
            `CSS_OFF_EVENT:  prdata <= {31'h0, flag_q};
            `CSS_OFF_MASK:   prdata <= {31'h0, mask_q};
            default:         prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Source clock sampling and crystal qualification
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rc_sync_q <= 3'h0;
         xt_sync_q <= 3'h0;
      end else begin
         rc_sync_q <= {rc_sync_q[1:0], rc_clock};
         xt_sync_q <= {xt_sync_q[1:0], xtal_clock}; // R15
      end
   end

   // Count crystal edges, and RC edges between crystal edges; silence means loss
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         good_cnt_q   <= 8'h00;
         loss_cnt_q   <= 8'h00;
         xtal_valid_q <= 1'b0;
      end else begin
         if (xt_rise) begin
            loss_cnt_q <= 8'h00;
            if (good_cnt_q != `CSS_XTAL_GOOD_EDGES) begin
               good_cnt_q <= good_cnt_q + 8'h01;
            end else begin
               xtal_valid_q <= 1'b1; // R15 R2
            end
         end else if (rc_rise) begin
            if (loss_cnt_q == `CSS_XTAL_LOSS_TICKS) begin
               good_cnt_q   <= 8'h00;
               xtal_valid_q <= 1'b0; // R4
            end else begin
               loss_cnt_q <= loss_cnt_q + 8'h01;
            end
         end
      end
   end

   // The crystal oscillator stays powered on backup as well
   assign xtal_osc_enable = 1'b1; // R12

   // ---------------------------------------------------------------
   // Switch sequencer: hand over only while RC is low and target low
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_q        <= clock_source_select_32k_pkg::SRC_RC; // R1
         sel_xtal_q   <= 1'b0;
         src_change_q <= 1'b0;
      end else begin
         src_change_q <= 1'b0;
         unique case (src_q)
            clock_source_select_32k_pkg::SRC_RC: begin
               if (xtal_valid_q) begin
                  src_q <= clock_source_select_32k_pkg::SRC_TO_XTAL;
               end
            end
            clock_source_select_32k_pkg::SRC_TO_XTAL: begin
               if (!xtal_valid_q) begin
                  src_q <= clock_source_select_32k_pkg::SRC_RC;
               end else if (!rc_sync_q[1] && !xt_sync_q[1]) begin
                  src_q        <= clock_source_select_32k_pkg::SRC_XTAL; // R3
                  sel_xtal_q   <= 1'b1; // R2 R5
                  src_change_q <= 1'b1; // R6
               end
            end
            clock_source_select_32k_pkg::SRC_XTAL: begin
               if (!xtal_valid_q) begin
                  src_q <= clock_source_select_32k_pkg::SRC_TO_RC; // R4
               end
            end
            clock_source_select_32k_pkg::SRC_TO_RC: begin
               if (!rc_sync_q[1]) begin
                  src_q        <= clock_source_select_32k_pkg::SRC_RC; // R3
                  sel_xtal_q   <= 1'b0; // R4 R5
                  src_change_q <= 1'b1; // R6
               end
            end
         endcase
      end
   end

   assign clock_source_status = sel_xtal_q; // R5

   // Output clock: holds its level in the switch states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_q <= 1'b0;
      end else begin
         unique case (src_q)
            clock_source_select_32k_pkg::SRC_RC:   clk_q <= rc_sync_q[1]; // R1
            clock_source_select_32k_pkg::SRC_XTAL: clk_q <= xt_sync_q[1]; // R2
            default:                               clk_q <= clk_q; // R3
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Output gating
   // ---------------------------------------------------------------
   always_comb begin
      proc_en = 1'b0;
      if (startup_done && ctrl_q[`CSS_CTRL_PROC_EN]) begin // R7 R9
         unique case (power_state)
            clock_source_select_32k_pkg::PWR_ON:      proc_en = 1'b1;
            clock_source_select_32k_pkg::PWR_STARTUP: proc_en = 1'b1;
            clock_source_select_32k_pkg::PWR_LOW_OFF:
               proc_en = ctrl_q[`CSS_CTRL_LP_OFF_ON]
                       | ctrl_q[`CSS_CTRL_RIGHTS]; // R8 R13
            clock_source_select_32k_pkg::PWR_OFF:
               proc_en = ctrl_q[`CSS_CTRL_RIGHTS]; // R13
         endcase
      end
      if (ctrl_q[`CSS_CTRL_RIGHTS]) begin
         proc_en = 1'b1; // R13
      end
   end

   assign periph_en = startup_done &
      (power_state == clock_source_select_32k_pkg::PWR_ON); // R10

   // Registered clock outputs and drive setting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         processor_clock_out        <= 1'b0;
         peripheral_clock_out       <= 1'b0;
         peripheral_clock_oe        <= 1'b0;
         peripheral_clock_drive_sel <= `CSS_DRV_DEFAULT;
      end else begin
         processor_clock_out  <= clk_q & proc_en; // R7 R8
         peripheral_clock_out <= clk_q & periph_en; // R7 R10
         peripheral_clock_oe  <= (ctrl_q[`CSS_CTRL_DRV_HI:`CSS_CTRL_DRV_LO]
                                  != `CSS_DRV_HIGHZ); // R11
         peripheral_clock_drive_sel <=
            ctrl_q[`CSS_CTRL_DRV_HI:`CSS_CTRL_DRV_LO]; // R11
      end
   end

endmodule
`default_nettype wire

// ---- clock_source_select_32k_cfg.svh ----
// Constants of the 32 kHz clock source selector
`ifndef CLOCK_SOURCE_SELECT_32K_CFG_SVH
`define CLOCK_SOURCE_SELECT_32K_CFG_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define CSS_OFF_CTRL        12'h000
`define CSS_OFF_STATUS      12'h004
`define CSS_OFF_EVENT       12'h008
`define CSS_OFF_MASK        12'h00c

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define CSS_CTRL_PROC_EN    0
`define CSS_CTRL_RIGHTS     1
`define CSS_CTRL_LP_OFF_ON  2
`define CSS_CTRL_DRV_LO     3
`define CSS_CTRL_DRV_HI     4
`define CSS_CTRL_RESET      5'h01

// ---------------------------------------------------------------
// Event and mask bits
// ---------------------------------------------------------------
`define CSS_EV_SRC_CHANGE   0
`define CSS_MASK_RESET      1'h1

// ---------------------------------------------------------------
// Peripheral drive settings
// ---------------------------------------------------------------
`define CSS_DRV_DEFAULT     2'h0
`define CSS_DRV_STRONG      2'h1
`define CSS_DRV_HIGHZ       2'h2
`define CSS_DRV_WEAK        2'h3

// ---------------------------------------------------------------
// Crystal qualification: good edges needed, and a silence limit
// ---------------------------------------------------------------
`define CSS_XTAL_GOOD_EDGES 8'h40
`define CSS_XTAL_LOSS_TICKS 8'h04
// Arbitrary identification value
`define CSS_ID_VALUE        8'h5a

`endif

// ---- clock_source_select_32k_pkg.sv ----
// Types of the 32 kHz clock source selector
package clock_source_select_32k_pkg;

   // Power states reported by the power state machine
   typedef enum logic [1:0] {
      PWR_OFF      = 2'b00,
      PWR_LOW_OFF  = 2'b01,
      PWR_ON       = 2'b10,
      PWR_STARTUP  = 2'b11
   } power_state_type;

   // Source switch sequencer
   typedef enum logic [1:0] {
      SRC_RC       = 2'b00,
      SRC_TO_XTAL  = 2'b01,
      SRC_XTAL     = 2'b10,
      SRC_TO_RC    = 2'b11
   } source_state_type;

endpackage

// ---- clock_source_select_32k_properties.sv ----
// Concurrent checks on the ports of the 32 kHz clock source selector
`timescale 1ns/10ps
`default_nettype none
module clock_source_select_32k_properties (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        rc_clock,
   input wire logic        xtal_clock,
   input wire logic        startup_done,
   input wire clock_source_select_32k_pkg::power_state_type power_state,
   input wire logic        peripheral_clock_out,
   input wire logic        peripheral_clock_oe,
   input wire logic [1:0]  peripheral_clock_drive_sel,
   input wire logic        clock_source_status,
   input wire logic        irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic       rc_p_q;
   logic       xt_p_q;
   logic [3:0] rc_rise_q;
   logic       acc;
   logic       per_ok;
   assign acc    = psel && penable;
   assign per_ok = startup_done && power_state == clock_source_select_32k_pkg::PWR_ON;
   // RC rises seen since the last crystal rise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rc_p_q    <= 1'b0;
         xt_p_q    <= 1'b0;
         rc_rise_q <= 4'h0;
      end else begin
         rc_p_q <= rc_clock;
         xt_p_q <= xtal_clock;
         if (xtal_clock && !xt_p_q) rc_rise_q <= 4'h0;
         else if (rc_clock && !rc_p_q && rc_rise_q != 4'hf) rc_rise_q <= rc_rise_q + 4'h1;
      end
   end
   a_zero_wait: assert property (psel |-> pready) else $error("pready low");
   a_unmapped_err: assert property (acc && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h00c)) else $error("pslverr wrong");
   a_drive_copy: assert property (acc && pwrite && paddr == 12'h000 |-> ##2 peripheral_clock_drive_sel == $past(pwdata[4:3], 2)) else $error("drive copy");
   a_highz_oe: assert property (peripheral_clock_drive_sel == 2'h2 && $past(peripheral_clock_drive_sel) == 2'h2 |-> !peripheral_clock_oe) else $error("oe in high z");
   a_periph_gated: assert property ((!per_ok)[*3] |-> !peripheral_clock_out) else $error("periph clock outside on");
   a_crystal_loss: assert property (rc_rise_q == 4'h8 |-> !clock_source_status) else $error("no fall back");
   a_irq_cause: assert property ($rose(irq) |-> clock_source_status != $past(clock_source_status, 2) || $past(acc && pwrite && paddr == 12'h00c)) else $error("irq without cause");
   a_irq_clear: assert property (acc && !pwrite && paddr == 12'h008 |=> !irq || $changed(clock_source_status)) else $error("irq not cleared");
   c_to_xtal: cover property ($rose(clock_source_status));
   c_to_rc: cover property ($fell(clock_source_status));
   c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// ---- tb_clock_source_select_32k.sv ----
// Self-checking bench of the 32 kHz clock source selector
`timescale 1ns/10ps
`default_nettype none
`include "clock_source_select_32k_cfg.svh"
module tb_clock_source_select_32k;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, main_supply_node = 1'b1, startup_done = 1'b0;
   logic xtal_run = 1'b0, pready, pslverr, rc_clock, xtal_clock, sl;
   logic meas = 1'b0;
   logic proc, periph, oe, status, irq;
   logic [1:0] drv;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   clock_source_select_32k_pkg::power_state_type power_state =
      clock_source_select_32k_pkg::PWR_OFF;
   int err_total = 0, tests_run = 0, cyc = 0, min_high;
   logic [7:0] tbl [6] = '{8'h51, 8'h11, 8'h35, 8'h31, 8'h02, 8'h41};
   logic [1:0] txp [6] = '{2'h3, 2'h0, 2'h2, 2'h0, 2'h2, 2'h0};
   always #25 pclk = ~pclk;
   clock_source_select_32k dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rc_clock(rc_clock),
      .xtal_clock(xtal_clock), .main_supply_node(main_supply_node),
      .startup_done(startup_done), .power_state(power_state),
      .processor_clock_out(proc), .peripheral_clock_out(periph),
      .peripheral_clock_oe(oe), .peripheral_clock_drive_sel(drv),
      .clock_source_status(status), .xtal_osc_enable(), .irq(irq));
   clock_far_side_model far_u (.pclk(pclk), .xtal_run(xtal_run),
      .measure(meas),
      .processor_clock_out(proc), .rc_clock(rc_clock),
      .xtal_clock(xtal_clock), .min_high(min_high));
   // Compare and count
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One APB transfer, held until pready at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      sl = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk("register", exp, rd & m);
   endtask
   // Watch both clock outputs for activity, bit 1 processor
   task automatic act(input logic [1:0] exp);
      logic a, b;
      logic [1:0] seen;
      seen = 2'h0;
      repeat (2) @(posedge pclk);
      a = proc;
      b = periph;
      repeat (40) begin
         @(negedge pclk);
         seen = seen | {proc !== a, periph !== b};
         a = proc;
         b = periph;
      end
      chk("activity", exp, seen);
   endtask
   task automatic wait_src(input logic v);
      int n;
      n = 0;
      while (status !== v && n < 3000) begin
         @(posedge pclk);
         n++;
      end
   endtask
   task automatic results;
      $display("Comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Cut a hang short
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         results;
      end
   end
   initial begin
      void'($urandom(48290));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(`CSS_OFF_CTRL, 32'hffffffff, 32'h1);
      rdchk(`CSS_OFF_MASK, 32'hffffffff, 32'h1);
      rdchk(`CSS_OFF_STATUS, 32'hff07, {`CSS_ID_VALUE, 8'h0});
      rdchk(12'h010, 32'hffffffff, 32'h0);
      chk("slverr", 32'h1, {31'h0, sl});
      power_state <= clock_source_select_32k_pkg::PWR_ON;
      startup_done <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, `CSS_OFF_CTRL, ($urandom & 32'hffffffe0) | (i << 3) | 32'h1);
         rdchk(`CSS_OFF_CTRL, 32'h1f, (i << 3) | 32'h1);
         @(posedge pclk);
         chk("drive", i, {30'h0, drv});
         chk("oe", (i != 2), {31'h0, oe});
      end
      // Table: state, startup, control low bits against activity
      for (int i = 0; i < 6; i++) begin
         power_state <=
            clock_source_select_32k_pkg::power_state_type'(tbl[i][6:5]);
         startup_done <= tbl[i][4];
         apb(1'b1, `CSS_OFF_CTRL, {28'h0, tbl[i][3:0]});
         act(txp[i]);
      end
      power_state <= clock_source_select_32k_pkg::PWR_ON;
      startup_done <= 1'b1;
      apb(1'b1, `CSS_OFF_CTRL, 32'h1);
      repeat (2) @(posedge pclk);
      while (proc !== 1'b0) @(posedge pclk);
      meas <= 1'b1;
      main_supply_node <= 1'b0;
      xtal_run <= 1'b1;
      wait_src(1'b1);
      chk("source", 32'h1, {31'h0, status});
      chk("irq", 32'h0, {31'h0, irq});
      rdchk(`CSS_OFF_EVENT, 32'h1, 32'h1);
      rdchk(`CSS_OFF_EVENT, 32'h1, 32'h0);
      rdchk(`CSS_OFF_STATUS, 32'h7, 32'h7);
      apb(1'b1, `CSS_OFF_MASK, 32'h0);
      xtal_run <= 1'b0;
      wait_src(1'b0);
      @(posedge pclk);
      chk("source", 32'h0, {31'h0, status});
      chk("irq", 32'h1, {31'h0, irq});
      rdchk(`CSS_OFF_EVENT, 32'h1, 32'h1);
      @(posedge pclk);
      chk("irq", 32'h0, {31'h0, irq});
      chk("pulse", 32'h1, {31'h0, min_high >= 3});
      results;
   end
endmodule
bind clock_source_select_32k clock_source_select_32k_properties chk_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .rc_clock(rc_clock), .xtal_clock(xtal_clock),
   .startup_done(startup_done), .power_state(power_state),
   .peripheral_clock_out(peripheral_clock_out),
   .peripheral_clock_oe(peripheral_clock_oe),
   .peripheral_clock_drive_sel(peripheral_clock_drive_sel),
   .clock_source_status(clock_source_status), .irq(irq));
`default_nettype wire
